// ---- include/sdwc_defs.svh ----
// Purpose: constants of the dual wiper serial control block
// Assumes: core clock 20 MHz
// Notes:   timing counts derive from printed times
`ifndef SDWC_DEFS_SVH
`define SDWC_DEFS_SVH

`define SDWC_CLK_HZ        20000000
`define SDWC_NVW_TIME_MS   20
`define SDWC_NVW_CYCLES    ((`SDWC_NVW_TIME_MS * `SDWC_CLK_HZ) / 1000)
`define SDWC_ID_BYTE       8'h50
`define SDWC_OP_READ       4'hb
`define SDWC_OP_WRITE      4'hc
`define SDWC_ADDR_W0       4'h0
`define SDWC_ADDR_W1       4'h1
`define SDWC_ADDR_GP_LAST  4'h6
`define SDWC_ADDR_ACR      4'h8
`define SDWC_WIPER_RESET   7'h40
`define SDWC_ACR_VOL       7
`define SDWC_ACR_SHUTDOWN_N      6
`define SDWC_ACR_WIP       5
`define SDWC_BIT_LAST      3'h7

`endif

// ---- include/sdwc_pkg.sv ----
// Purpose: types of the dual wiper serial control block
// Assumes: nothing
// Notes:   constants live in sdwc_defs.svh
package sdwc_pkg;
  typedef enum logic [1:0] {
    SDWC_ID   = 2'b00,
    SDWC_CMD  = 2'b01,
    SDWC_DATA = 2'b10,
    SDWC_SKIP = 2'b11
  } sdwc_phase_t;
endpackage

// ---- hdl/sdwc_sync.sv ----
// Purpose: three-stage pin synchroniser with agreement check
// Assumes: input from another domain
// Notes:   stage one feeds only stage two
module sdwc_sync (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic pin_in,
  input  wire logic reset_val,
  output logic      level_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg    <= 1'b0;
      s2_reg    <= 1'b0;
      s3_reg    <= 1'b0;
      level_out <= 1'b0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // Change counts once stages two and three agree
      if (s2_reg == s3_reg) begin
        level_out <= s3_reg;
      end
    end
  end
endmodule

// ---- hdl/sdwc_nvw_timer.sv ----
// Purpose: self-timed non-volatile write cycle
// Assumes: start is a one-cycle pulse
// Notes:   count is a parameter so benches can shorten it
`include "sdwc_defs.svh"
module sdwc_nvw_timer #(
  parameter int unsigned NVW_CYCLES = `SDWC_NVW_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic start,
  output logic      busy
);
  logic [19:0] count_reg;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= 20'h00000;
      busy      <= 1'b0;
    end else if (start && !busy) begin
      count_reg <= 20'(NVW_CYCLES - 1);
      busy      <= 1'b1;
    end else if (busy) begin
      count_reg <= count_reg - 20'h00001;
      busy      <= (count_reg != 20'h00000);
    end
  end
endmodule

// ---- hdl/sdwc_core.sv ----
// Purpose: serial slave and control for two wiper position registers
// Assumes: SPI mode 0, serial clock well below core clock
// Notes:   non-volatile store modelled as flip-flops
//
// Behaviour
// - Wiper value drives tap select output
// - Shutdown opens ends, wiper to low
// - Wiper registers kept through shutdown
// - Run only when pin and bit high
// - Serial access continues during shutdown
// - Output only pulls low or releases
// - Read data shifts on falling edge
// - Sample input on rising edge, selected
// - Ignore activity until first select fall
// - Select low makes device active
// - Select high releases output, ignores clock
// - Standby when deselected unless writing
// - Non-volatile write self-timed after deselect
// - Read code 1011, write code 1100
// - Bytes travel most significant bit first
// - Writes rejected while write in progress
// - Shutdown bit resets to one
`include "sdwc_defs.svh"
module sdwc_core
  import sdwc_pkg::*;
#(
  parameter int unsigned NVW_CYCLES = `SDWC_NVW_CYCLES
) (
  input  wire logic  core_clk,
  input  wire logic  reset_n,
  input  wire logic  sck,
  input  wire logic  cs_n,
  input  wire logic  sdi,
  input  wire logic  shutdown_n,
  output logic       sdo_out,
  output logic       sdo_oe,
  output logic [6:0] tap_sel0,
  output logic [6:0] tap_sel1,
  output logic       ends_open,
  output logic       wiper_to_low,
  output logic       standby,
  output logic       write_in_progress
);
  // ************************
  // Input synchronisers
  // ************************
  logic sck_s;
  logic cs_n_s;
  logic sdi_s;
  logic shutdown_n_s;
  logic sck_d_reg;
  logic cs_n_d_reg;

  sdwc_sync u_sck  (.core_clk(core_clk), .reset_n(reset_n), .pin_in(sck),        .reset_val(1'b0), .level_out(sck_s));
  sdwc_sync u_cs   (.core_clk(core_clk), .reset_n(reset_n), .pin_in(cs_n),       .reset_val(1'b1), .level_out(cs_n_s));
  sdwc_sync u_sdi  (.core_clk(core_clk), .reset_n(reset_n), .pin_in(sdi),        .reset_val(1'b0), .level_out(sdi_s));
  sdwc_sync u_shutdown_n (.core_clk(core_clk), .reset_n(reset_n), .pin_in(shutdown_n), .reset_val(1'b0), .level_out(shutdown_n_s));

  // ************************
  // Edge detection
  // ************************
  logic armed_reg;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic active;

  // Select reads as low at reset, so a pin high is needed first
  assign cs_fall  = cs_n_d_reg & ~cs_n_s;
  assign cs_rise  = ~cs_n_d_reg & cs_n_s;
  assign active   = armed_reg & ~cs_n_s;
  assign sck_rise = active & ~sck_d_reg & sck_s;
  assign sck_fall = active & sck_d_reg & ~sck_s;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_d_reg  <= 1'b0;
      cs_n_d_reg <= 1'b0;
      armed_reg  <= 1'b0;
    end else begin
      sck_d_reg  <= sck_s;
      cs_n_d_reg <= cs_n_s;
      if (cs_fall) begin
        armed_reg <= 1'b1;
      end
    end
  end

  // ************************
  // Registers
  // ************************
  logic [6:0] wiper_position_reg [2];
  logic [6:0] initial_value_store [2];
  logic [7:0] gp_store_reg [5];
  logic       vol_reg;
  logic       shutdown_n_bit_reg;
  logic       nvw_busy;
  logic       nvw_pend_reg;
  logic       nvw_start;

  // ************************
  // Serial shifter
  // ************************
  sdwc_phase_t phase_reg;
  logic [2:0]  bit_cnt_reg;
  logic [7:0]  shift_in_reg;
  logic [7:0]  shift_out_reg;
  logic [3:0]  addr_reg;
  logic        is_read_reg;
  logic [7:0]  byte_in;
  logic        byte_done;
  logic [7:0]  rd_data;
  logic [3:0]  addr_inc;
  logic        wr_ok;
  logic        wr_byte;

  assign byte_in   = {shift_in_reg[6:0], sdi_s};
  assign byte_done = sck_rise & (bit_cnt_reg == `SDWC_BIT_LAST);
  assign wr_ok     = ~nvw_busy;
  assign wr_byte   = byte_done & (phase_reg == SDWC_DATA) & ~is_read_reg & wr_ok;
  assign nvw_start = nvw_pend_reg & cs_n_s;

  function automatic logic [3:0] next_addr(input logic [3:0] a);
    // Pointer wraps after the last general purpose slot
    if (a == `SDWC_ADDR_GP_LAST) begin
      next_addr = `SDWC_ADDR_W0;
    end else if (a < `SDWC_ADDR_GP_LAST) begin
      next_addr = a + 4'h1;
    end else begin
      next_addr = a;
    end
  endfunction

  function automatic logic [7:0] read_reg(input logic [3:0] a);
    if (a == `SDWC_ADDR_ACR) begin
      read_reg = {vol_reg, shutdown_n_bit_reg, nvw_busy, 5'h00};
    end else if (a <= `SDWC_ADDR_W1) begin
      read_reg = {1'b0, vol_reg ? wiper_position_reg[a[0]] : initial_value_store[a[0]]};
    end else if (a <= `SDWC_ADDR_GP_LAST) begin
      read_reg = gp_store_reg[3'(a - 4'h2)];
    end else begin
      read_reg = 8'h00;
    end
  endfunction

  assign addr_inc = next_addr(addr_reg);
  assign rd_data  = read_reg(byte_done && phase_reg == SDWC_CMD ? byte_in[3:0] : addr_inc);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_reg     <= SDWC_ID;
      bit_cnt_reg   <= 3'h0;
      shift_in_reg  <= 8'h00;
      shift_out_reg <= 8'hff;
      addr_reg      <= 4'h0;
      is_read_reg   <= 1'b0;
    end else if (!active) begin
      phase_reg     <= SDWC_ID;
      bit_cnt_reg   <= 3'h0;
      shift_out_reg <= 8'hff;
    end else if (sck_rise) begin
      bit_cnt_reg  <= bit_cnt_reg + 3'h1;
      shift_in_reg <= byte_in;
      if (byte_done) begin
        unique case (phase_reg)
          SDWC_ID: begin
            phase_reg <= (byte_in == `SDWC_ID_BYTE) ? SDWC_CMD : SDWC_SKIP;
          end
          SDWC_CMD: begin
            addr_reg    <= byte_in[3:0];
            is_read_reg <= (byte_in[7:4] == `SDWC_OP_READ);
            phase_reg   <= (byte_in[7:4] == `SDWC_OP_READ || byte_in[7:4] == `SDWC_OP_WRITE)
                           ? SDWC_DATA : SDWC_SKIP;
            shift_out_reg <= read_reg(byte_in[3:0]);
          end
          SDWC_DATA: begin
            addr_reg      <= addr_inc;
            shift_out_reg <= rd_data;
          end
          SDWC_SKIP: begin
            phase_reg <= SDWC_SKIP;
          end
        endcase
      end
    end
  end

  // ************************
  // Output driver
  // ************************
  logic out_bit_reg;
  logic first_reg;

  // Bit 7 goes out on the first fall after the command byte
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_bit_reg <= 1'b1;
      first_reg   <= 1'b1;
    end else if (!active) begin
      out_bit_reg <= 1'b1;
      first_reg   <= 1'b1;
    end else if (sck_fall && phase_reg == SDWC_DATA && is_read_reg) begin
      out_bit_reg <= shift_out_reg[3'h7 - bit_cnt_reg];
      first_reg   <= 1'b0;
    end
  end

  assign sdo_out = 1'b0;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sdo_oe <= 1'b0;
    end else begin
      sdo_oe <= active & is_read_reg & (phase_reg == SDWC_DATA) & ~first_reg & ~out_bit_reg;
    end
  end

  // ************************
  // Register writes
  // ************************
  logic wr_wiper;
  logic wr_nv;
  logic wr_acr;
  logic wr_gp;

  assign wr_wiper = wr_byte & (addr_reg <= `SDWC_ADDR_W1);
  assign wr_nv    = wr_wiper & ~vol_reg;
  assign wr_acr   = wr_byte & (addr_reg == `SDWC_ADDR_ACR);
  assign wr_gp    = wr_byte & (addr_reg > `SDWC_ADDR_W1) & (addr_reg <= `SDWC_ADDR_GP_LAST);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wiper_position_reg[0]  <= `SDWC_WIPER_RESET;
      wiper_position_reg[1]  <= `SDWC_WIPER_RESET;
      initial_value_store[0] <= `SDWC_WIPER_RESET;
      initial_value_store[1] <= `SDWC_WIPER_RESET;
      for (int i = 0; i < 5; i++) begin
        gp_store_reg[i] <= 8'h00;
      end
      vol_reg      <= 1'b0;
      shutdown_n_bit_reg <= 1'b1;
      nvw_pend_reg <= 1'b0;
    end else begin
      if (wr_wiper) begin
        wiper_position_reg[addr_reg[0]] <= byte_in[6:0];
      end
      if (wr_nv) begin
        initial_value_store[addr_reg[0]] <= byte_in[6:0];
      end
      if (wr_gp) begin
        gp_store_reg[3'(addr_reg - 4'h2)] <= byte_in;
      end
      if (wr_acr) begin
        vol_reg      <= byte_in[`SDWC_ACR_VOL];
        shutdown_n_bit_reg <= byte_in[`SDWC_ACR_SHUTDOWN_N];
      end
      if (wr_nv || wr_gp) begin
        nvw_pend_reg <= 1'b1;
      end else if (nvw_start) begin
        nvw_pend_reg <= 1'b0;
      end
    end
  end

  sdwc_nvw_timer #(.NVW_CYCLES(NVW_CYCLES)) u_nvw (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .start    (nvw_start),
    .busy     (nvw_busy)
  );

  // ************************
  // Analog control outputs
  // ************************
  logic run;
  assign run = shutdown_n_s & shutdown_n_bit_reg;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tap_sel0          <= `SDWC_WIPER_RESET;
      tap_sel1          <= `SDWC_WIPER_RESET;
      ends_open         <= 1'b1;
      wiper_to_low      <= 1'b1;
      standby           <= 1'b1;
      write_in_progress <= 1'b0;
    end else begin
      tap_sel0          <= wiper_position_reg[0];
      tap_sel1          <= wiper_position_reg[1];
      ends_open         <= ~run;
      wiper_to_low      <= ~run;
      standby           <= cs_n_s & ~nvw_busy & ~nvw_pend_reg;
      write_in_progress <= nvw_busy | nvw_pend_reg;
    end
  end

  // ************************
  // Assertions
  // ************************
  property p_shutdown_n_out;
    @(posedge core_clk) disable iff (!reset_n)
      ##1 ends_open == ~($past(shutdown_n_s) & $past(shutdown_n_bit_reg));
  endproperty
  a_shutdown_n_out: assert property (p_shutdown_n_out) else $error("shutdown output wrong");

  property p_wiper_low;
    @(posedge core_clk) disable iff (!reset_n) ends_open == wiper_to_low;
  endproperty
  a_wiper_low: assert property (p_wiper_low) else $error("wiper and ends disagree");

  property p_tap;
    @(posedge core_clk) disable iff (!reset_n) ##1 tap_sel0 == $past(wiper_position_reg[0]);
  endproperty
  a_tap: assert property (p_tap) else $error("tap not following register");

  property p_release;
    @(posedge core_clk) disable iff (!reset_n) !active |=> !sdo_oe;
  endproperty
  a_release: assert property (p_release) else $error("output driven while deselected");

  property p_wip_block;
    @(posedge core_clk) disable iff (!reset_n) nvw_busy |-> !wr_byte;
  endproperty
  a_wip_block: assert property (p_wip_block) else $error("write accepted while busy");

  sequence s_start;
    nvw_start;
  endsequence
  property p_selftimed;
    @(posedge core_clk) disable iff (!reset_n) s_start |=> nvw_busy;
  endproperty
  a_selftimed: assert property (p_selftimed) else $error("write cycle did not start");

  property p_cnt_clear;
    @(posedge core_clk) disable iff (!reset_n) !active |=> bit_cnt_reg == 3'h0;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("bit counter not cleared");

  property p_unarmed;
    @(posedge core_clk) disable iff (!reset_n) !armed_reg |-> !sck_rise && !sck_fall;
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("activity before first select fall");

  property p_standby;
    @(posedge core_clk) disable iff (!reset_n) nvw_busy |=> !standby;
  endproperty
  a_standby: assert property (p_standby) else $error("standby during write");
endmodule

// ---- test/sdwc_host.sv ----
// Purpose: serial host model driving select, clock and data
// Assumes: called at a rising core clock edge
// Notes:   serial clock stands low outside frames
module sdwc_host (
  input  wire logic core_clk,
  input  wire logic sdo_line,
  output logic      sck,
  output logic      cs_n,
  output logic      sdi
);
  timeunit 1ns;
  timeprecision 1ps;

  // Select low at power-up so that the first frame brings no fall
  initial begin
    sck  = 1'b0;
    cs_n = 1'b0;
    sdi  = 1'b0;
  end

  task automatic xfer(input logic [31:0] d, input int nbits, output logic [7:0] rd);
    rd = 8'h00;
    cs_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    for (int i = 0; i < nbits; i++) begin
      sdi <= d[31-i];
      repeat (4) @(posedge core_clk);
      sck <= 1'b1;
      repeat (4) @(posedge core_clk);
      // Sampled late in the high phase: the reply lags each fall
      rd = {rd[6:0], sdo_line};
      sck <= 1'b0;
    end
    repeat (6) @(posedge core_clk);
    cs_n <= 1'b1;
    // Released data line does not keep its last value
    sdi  <= ~sdi;
    repeat (40) @(posedge core_clk);
  endtask
endmodule

// ---- test/sdwc_core_tb.sv ----
// Purpose: self-checking bench of the dual wiper serial block
// Assumes: serial clock of 400 ns from the host model
// Notes:   write cycle shortened to 400 core cycles
module sdwc_core_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic       core_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       shutdown_n = 1'b1;
  wire        sck;
  wire        cs_n;
  wire        sdi;
  wire        sdo_line;
  logic       sdo_out;
  logic       sdo_oe;
  logic [6:0] tap_sel0;
  logic [6:0] tap_sel1;
  logic       ends_open;
  logic       wiper_to_low;
  logic       standby;
  logic       write_in_progress;
  int         n_errors = 0;
  int         checks = 0;
  int         wpr [2];
  int         sbit;
  logic [7:0] rd;
  logic [7:0] d;
  logic       a;

  always #25 core_clk = ~core_clk;
  // Pull-up on the open-drain data line
  assign sdo_line = sdo_oe ? sdo_out : 1'b1;

  sdwc_core #(.NVW_CYCLES(400)) sdwc_core_i (
    .core_clk(core_clk), .reset_n(reset_n), .sck(sck), .cs_n(cs_n), .sdi(sdi),
    .shutdown_n(shutdown_n), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .tap_sel0(tap_sel0),
    .tap_sel1(tap_sel1), .ends_open(ends_open), .wiper_to_low(wiper_to_low),
    .standby(standby), .write_in_progress(write_in_progress)
  );

  sdwc_host sdwc_host_i (.core_clk(core_clk), .sdo_line(sdo_line), .sck(sck), .cs_n(cs_n), .sdi(sdi));

  // ****************
  // Checking tasks
  // ****************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic model_taps();
    logic run;
    run = shutdown_n & sbit[0];
    chk("tap_sel0", 8'(wpr[0]), {1'b0, tap_sel0});
    chk("tap_sel1", 8'(wpr[1]), {1'b0, tap_sel1});
    chk("ends_open", {7'h00, !run}, {7'h00, ends_open});
    chk("wiper_to_low", {7'h00, !run}, {7'h00, wiper_to_low});
  endtask

  task automatic wr(input logic [3:0] adr, input logic [7:0] val, input int nbits);
    sdwc_host_i.xfer({8'h50, 4'hc, adr, val, 8'h00}, nbits, rd);
  endtask

  task automatic rdr(input logic [3:0] adr, input logic [7:0] exp);
    sdwc_host_i.xfer({8'h50, 4'hb, adr, 16'h0000}, 24, rd);
    chk("read data", exp, rd);
    chk("sdo_oe idle", 8'h00, {7'h00, sdo_oe});
  endtask

  task automatic final_report();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Hang guard, well beyond the expected run
  initial begin
    repeat (40000) @(posedge core_clk);
    n_errors++;
    final_report();
  end

  // ****************
  // Main sequence
  // ****************
  initial begin
    void'($urandom(80656));
    wpr = '{64, 64};
    sbit = 1;
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    wr(4'h8, 8'h80, 24);
    model_taps();
    chk("standby", 8'h01, {7'h00, standby});
    wr(4'h8, 8'hc0, 24);
    rdr(4'h8, 8'hc0);
    for (int i = 0; i < 12; i++) begin
      a = 1'($urandom_range(1, 0));
      d = (i == 0) ? 8'h00 : (i == 1) ? 8'h7f : 8'($urandom_range(127, 0));
      wr({3'h0, a}, d, 24);
      wpr[a] = d;
      model_taps();
      rdr({3'h0, a}, d);
    end
    shutdown_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    model_taps();
    wr(4'h0, 8'h11, 24);
    wpr[0] = 8'h11;
    model_taps();
    rdr(4'h0, 8'h11);
    shutdown_n <= 1'b1;
    repeat (10) @(posedge core_clk);
    model_taps();
    wr(4'h8, 8'h80, 24);
    sbit = 0;
    model_taps();
    wr(4'h8, 8'hc0, 24);
    sbit = 1;
    model_taps();
    for (int op = 0; op < 16; op++) begin
      sdwc_host_i.xfer({8'h50, 4'(op), 4'h0, 8'h22 + 8'(op), 8'h00}, 24, rd);
      if (op == 12) begin
        wpr[0] = 8'h22 + op;
      end
      model_taps();
    end
    sdwc_host_i.xfer({8'h51, 8'hc1, 8'h33, 8'h00}, 24, rd);
    model_taps();
    wr(4'h1, 8'h55, 20);
    model_taps();
    wr(4'h1, 8'h66, 24);
    wpr[1] = 8'h66;
    model_taps();
    // Volatile flag cleared: next wiper write also starts a stored write
    wr(4'h8, 8'h40, 24);
    wr(4'h0, 8'h5a, 24);
    wpr[0] = 8'h5a;
    model_taps();
    chk("wip busy", 8'h01, {7'h00, write_in_progress});
    chk("standby busy", 8'h00, {7'h00, standby});
    wr(4'h1, 8'h77, 24);
    model_taps();
    for (int k = 0; k < 1000 && write_in_progress !== 1'b0; k++) begin
      @(posedge core_clk);
    end
    @(posedge core_clk);
    chk("wip done", 8'h00, {7'h00, write_in_progress});
    chk("standby done", 8'h01, {7'h00, standby});
    rdr(4'h0, 8'h5a);
    final_report();
  end
endmodule
